// ===== common/tsp_pkg.sv
// Package for the sensor register map and its two-wire link.
// Assumes clk_sys at 25 MHz on both ends.
package tsp_pkg;
  // Selector codes of the seven data registers
  localparam logic [7:0] TSP_SEL_TEMP    = 8'h00;
  localparam logic [7:0] TSP_SEL_CFG     = 8'h01;
  localparam logic [7:0] TSP_SEL_LOW     = 8'h02;
  localparam logic [7:0] TSP_SEL_HIGH    = 8'h03;
  localparam logic [7:0] TSP_SEL_NV_CFG  = 8'h11;
  localparam logic [7:0] TSP_SEL_NV_LOW  = 8'h12;
  localparam logic [7:0] TSP_SEL_NV_HIGH = 8'h13;
  // Extra command byte: copy stored set into active set
  localparam logic [7:0] TSP_CMD_COPY    = 8'hA8;
  // Fixed upper nibble of the device address byte
  localparam logic [3:0] TSP_ADDR_FIXED  = 4'h9;
  // Reset values
  localparam logic [7:0]  TSP_SEL_RST     = 8'h00;
  localparam logic [15:0] TSP_TEMP_RST    = 16'h0000;
  localparam logic [15:0] TSP_NV_CFG_RST  = 16'h0000;
  localparam logic [15:0] TSP_NV_LOW_RST  = 16'h4B00;
  localparam logic [15:0] TSP_NV_HIGH_RST = 16'h5000;
  // Controller APB map
  localparam logic [7:0] TSP_APB_CTRL   = 8'h00;
  localparam logic [7:0] TSP_APB_WDATA  = 8'h04;
  localparam logic [7:0] TSP_APB_STATUS = 8'h08;
  localparam logic [7:0] TSP_APB_RDATA  = 8'h0C;
  // CTRL fields
  localparam int TSP_CTRL_PTR_LSB   = 0;
  localparam int TSP_CTRL_OP_LSB    = 8;
  localparam int TSP_CTRL_TWO_BIT   = 10;
  localparam int TSP_CTRL_STRAP_LSB = 12;
  // STATUS fields
  localparam int TSP_STAT_BUSY_BIT = 0;
  localparam int TSP_STAT_NACK_BIT = 1;
  // Controller operations
  typedef enum logic [1:0] {
    TSP_OP_READ = 2'h0,
    TSP_OP_PTR  = 2'h1,
    TSP_OP_WR8  = 2'h2,
    TSP_OP_WR16 = 2'h3
  } tsp_op_t;
  // Link timing: quarter of a bit period
  localparam int TSP_CLK_NS  = 40;
  localparam int TSP_QTR_NS  = 2500;
  localparam int TSP_QTR_CYC = (TSP_QTR_NS + TSP_CLK_NS - 1) / TSP_CLK_NS;
  // State codes
  typedef enum logic [4:0] {
    TSP_D_IDLE = 5'h01,
    TSP_D_RX   = 5'h02,
    TSP_D_ACK  = 5'h04,
    TSP_D_TX   = 5'h08,
    TSP_D_MACK = 5'h10
  } tsp_dst_t;
  typedef enum logic [3:0] {
    TSP_H_IDLE  = 4'h1,
    TSP_H_START = 4'h2,
    TSP_H_BITS  = 4'h4,
    TSP_H_STOP  = 4'h8
  } tsp_hst_t;
endpackage : tsp_pkg

// ===== common/tsp_link_if.sv
// Two-wire link between sensor end and controller end.
// Open-drain wires with pull-ups resolved here from the enables.
`timescale 1ns/1ps
interface tsp_link_if;
  logic scl_h_o;
  logic scl_h_oe;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic scl;
  logic sda;
  // Wired-AND with pull-up
  assign scl = scl_h_oe ? scl_h_o : 1'b1;
  assign sda = (sda_h_oe ? sda_h_o : 1'b1) & (sda_d_oe ? sda_d_o : 1'b1);
  modport dev  (input scl, input sda, output sda_d_o, output sda_d_oe);
  modport host (input sda, output scl_h_o, output scl_h_oe, output sda_h_o, output sda_h_oe);
endinterface : tsp_link_if

// ===== hdl/tsp_sensor_dev.sv
// Sensor end: selector and seven data registers behind a two-wire slave.
// Assumes a controller that drives scl slowly against clk_sys.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module tsp_sensor_dev (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  tsp_link_if.dev          link,
  input  wire logic [2:0]  address_strap_pins,
  input  wire logic [15:0] temp_sample,
  input  wire logic        temp_sample_valid,
  input  wire logic        regs_locked,
  output logic             conv_start,
  output logic [15:0]      active_configuration,
  output logic [15:0]      active_low_limit,
  output logic [15:0]      active_high_limit
);
  import tsp_pkg::*;

  logic        scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
  logic [2:0]  strap_m, strap_s;
  tsp_dst_t    state_r;
  logic [3:0]  cnt_r;
  logic [7:0]  rx_r, tx_r, hi_r, sel_r;
  logic [2:0]  byte_r;
  logic        rw_r, ack_r, half_r, sda_oe_r, boot_r, conv_r;
  logic [15:0] temp_r, cfg_r, low_r, high_r, nv_cfg_r, nv_low_r, nv_high_r;
  logic [15:0] rd_word;
  logic        rise, fall, start_c, stop_c, rx_done, ptr_valid, data_ok;
  logic        addr_match, ack_nxt, copy_p, wr_hi, wr_lo, reading_temp;

  //////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for the pins, third flop for edges
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      scl_m   <= 1'b1;
      scl_s   <= 1'b1;
      scl_q   <= 1'b1;
      sda_m   <= 1'b1;
      sda_s   <= 1'b1;
      sda_q   <= 1'b1;
      strap_m <= 3'h0;
      strap_s <= 3'h0;
    end else begin
      scl_m   <= link.scl;
      scl_s   <= scl_m;
      scl_q   <= scl_s;
      sda_m   <= link.sda;
      sda_s   <= sda_m;
      sda_q   <= sda_s;
      strap_m <= address_strap_pins;
      strap_s <= strap_m;
    end
  end

  // Line events
  assign rise    = scl_s & ~scl_q;
  assign fall    = ~scl_s & scl_q;
  assign start_c = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_c  = scl_s & scl_q & ~sda_q & sda_s;

  //////////////////////////////////////////////////////////////////////////
  // Byte decode at the falling edge that ends a received byte
  assign rx_done    = (state_r == TSP_D_RX) & fall & (cnt_r == 4'h8);
  assign addr_match = (rx_r[7:1] == {TSP_ADDR_FIXED, strap_s});
  assign ptr_valid  = (rx_r[7:5] == 3'h0) &
                      (rx_r == TSP_SEL_TEMP   || rx_r == TSP_SEL_CFG ||
                       rx_r == TSP_SEL_LOW    || rx_r == TSP_SEL_HIGH ||
                       rx_r == TSP_SEL_NV_CFG || rx_r == TSP_SEL_NV_LOW ||
                       rx_r == TSP_SEL_NV_HIGH);
  assign data_ok    = (sel_r != TSP_SEL_TEMP) & ~regs_locked;
  assign copy_p     = rx_done & (byte_r == 3'h1) & (rx_r == TSP_CMD_COPY);
  assign wr_hi      = rx_done & (byte_r == 3'h2) & data_ok;
  assign wr_lo      = rx_done & (byte_r == 3'h3) & data_ok;
  assign reading_temp = (state_r == TSP_D_TX || state_r == TSP_D_MACK) &
                        (sel_r == TSP_SEL_TEMP);

  // ACK decision per byte position
  always_comb begin
    unique case (byte_r)
      3'h0:    ack_nxt = addr_match;
      3'h1:    ack_nxt = ptr_valid | (rx_r == TSP_CMD_COPY);
      3'h2:    ack_nxt = data_ok;
      3'h3:    ack_nxt = data_ok;
      default: ack_nxt = 1'b0;
    endcase
  end

  // Read word by selector
  always_comb begin
    unique case (sel_r)
      TSP_SEL_TEMP:    rd_word = temp_r;
      TSP_SEL_CFG:     rd_word = cfg_r;
      TSP_SEL_LOW:     rd_word = low_r;
      TSP_SEL_HIGH:    rd_word = high_r;
      TSP_SEL_NV_CFG:  rd_word = nv_cfg_r;
      TSP_SEL_NV_LOW:  rd_word = nv_low_r;
      TSP_SEL_NV_HIGH: rd_word = nv_high_r;
      default:         rd_word = 16'h0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Link state machine; start and stop override every state
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r  <= TSP_D_IDLE;
      cnt_r    <= 4'h0;
      rx_r     <= 8'h00;
      tx_r     <= 8'h00;
      byte_r   <= 3'h0;
      rw_r     <= 1'b0;
      ack_r    <= 1'b0;
      half_r   <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (start_c) begin
      state_r  <= TSP_D_RX;
      cnt_r    <= 4'h0;
      byte_r   <= 3'h0;
      rw_r     <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (stop_c) begin
      state_r  <= TSP_D_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      unique case (state_r)
        TSP_D_IDLE: begin
        end
        TSP_D_RX: begin
          if (rise) begin
            rx_r  <= {rx_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
          end
          if (rx_done) begin
            ack_r    <= ack_nxt;
            sda_oe_r <= ack_nxt;
            state_r  <= TSP_D_ACK;
            if (byte_r == 3'h0) begin
              rw_r <= rx_r[0];
            end
          end
        end
        TSP_D_ACK: begin
          if (fall) begin
            cnt_r    <= 4'h0;
            sda_oe_r <= 1'b0;
            byte_r   <= (byte_r == 3'h4) ? byte_r : byte_r + 3'h1;
            if (!ack_r) begin
              state_r <= TSP_D_IDLE;
            end else if (rw_r) begin
              state_r  <= TSP_D_TX;
              half_r   <= 1'b0;
              tx_r     <= rd_word[15:8];
              sda_oe_r <= ~rd_word[15];
            end else begin
              state_r <= TSP_D_RX;
            end
          end
        end
        TSP_D_TX: begin
          if (rise) begin
            cnt_r <= cnt_r + 4'h1;
          end
          if (fall) begin
            if (cnt_r == 4'h8) begin
              sda_oe_r <= 1'b0;
              state_r  <= TSP_D_MACK;
            end else begin
              tx_r     <= {tx_r[6:0], 1'b0};
              sda_oe_r <= ~tx_r[6];
            end
          end
        end
        TSP_D_MACK: begin
          if (rise) begin
            ack_r <= ~sda_s;
          end
          if (fall) begin
            if (ack_r) begin
              state_r  <= TSP_D_TX;
              cnt_r    <= 4'h0;
              half_r   <= ~half_r;
              tx_r     <= half_r ? rd_word[15:8] : rd_word[7:0];
              sda_oe_r <= half_r ? ~rd_word[15] : ~rd_word[7];
            end else begin
              state_r <= TSP_D_IDLE;
            end
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Selector: only the first written byte, only listed codes
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sel_r <= TSP_SEL_RST;
    end else if (rx_done && byte_r == 3'h1 && ptr_valid) begin
      sel_r <= rx_r;
    end
  end

  // Upper data byte held until the lower one arrives
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hi_r <= 8'h00;
    end else if (wr_hi) begin
      hi_r <= rx_r;
    end
  end

  // Active and stored sets
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfg_r     <= TSP_NV_CFG_RST;
      low_r     <= TSP_NV_LOW_RST;
      high_r    <= TSP_NV_HIGH_RST;
      nv_cfg_r  <= TSP_NV_CFG_RST;
      nv_low_r  <= TSP_NV_LOW_RST;
      nv_high_r <= TSP_NV_HIGH_RST;
    end else if (copy_p) begin
      cfg_r  <= nv_cfg_r;
      low_r  <= nv_low_r;
      high_r <= nv_high_r;
    end else begin
      if (wr_hi && sel_r == TSP_SEL_CFG) begin
        cfg_r[15:8] <= rx_r;
      end
      if (wr_hi && sel_r == TSP_SEL_NV_CFG) begin
        nv_cfg_r[15:8] <= rx_r;
      end
      if (wr_lo) begin
        unique case (sel_r)
          TSP_SEL_CFG:     cfg_r     <= {hi_r, rx_r};
          TSP_SEL_LOW:     low_r     <= {hi_r, rx_r};
          TSP_SEL_HIGH:    high_r    <= {hi_r, rx_r};
          TSP_SEL_NV_CFG:  nv_cfg_r  <= {hi_r, rx_r};
          TSP_SEL_NV_LOW:  nv_low_r  <= {hi_r, rx_r};
          TSP_SEL_NV_HIGH: nv_high_r <= {hi_r, rx_r};
          default: begin
          end
        endcase
      end
    end
  end

  // Temperature result, frozen while it is being shifted out
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      temp_r <= TSP_TEMP_RST;
    end else if (temp_sample_valid && !reading_temp) begin
      temp_r <= temp_sample;
    end
  end

  // Single conversion request after reset release
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      boot_r <= 1'b1;
      conv_r <= 1'b0;
    end else begin
      boot_r <= 1'b0;
      conv_r <= boot_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs: only the active set leaves the block
  assign active_configuration = cfg_r;
  assign active_low_limit     = low_r;
  assign active_high_limit    = high_r;
  assign conv_start           = conv_r;
  assign link.sda_d_o         = 1'b0;
  assign link.sda_d_oe        = sda_oe_r;
endmodule : tsp_sensor_dev

// ===== hdl/tsp_bus_master.sv
// Controller end: APB-programmed two-wire master for the sensor.
// Assumes an APB master on clk_sys and a sensor that never stretches scl.
`timescale 1ns/1ps
module tsp_bus_master (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  tsp_link_if.host         link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  import tsp_pkg::*;

  localparam logic [6:0] QTR_LAST = 7'(TSP_QTR_CYC - 1);

  logic        sda_m, sda_s, pready_r, pslverr_r, nack_r, go;
  logic [31:0] prdata_r;
  logic [7:0]  ptr_r, sh_r, tx_byte;
  tsp_op_t     op_r;
  logic        two_r, is_rx, last, nak_bit, scl_oe_r, sda_oe_r;
  logic [2:0]  strap_r;
  logic [15:0] wdata_r, rdata_r;
  tsp_hst_t    state_r;
  logic [6:0]  qcnt_r;
  logic [1:0]  ph_r, byte_r, nlast;
  logic [3:0]  bit_r;
  logic        tick;

  //////////////////////////////////////////////////////////////////////////
  // APB slave, one access cycle, registered answer
  assign go = psel & penable & pready_r & pwrite & (paddr == TSP_APB_CTRL) &
              (state_r == TSP_H_IDLE);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= psel & ~penable;
      pslverr_r <= psel & ~penable & ~(paddr == TSP_APB_CTRL ||
                   paddr == TSP_APB_WDATA || paddr == TSP_APB_STATUS ||
                   paddr == TSP_APB_RDATA);
      prdata_r  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          TSP_APB_CTRL:   prdata_r <= {17'h0, strap_r, 1'b0, two_r, op_r, ptr_r};
          TSP_APB_WDATA:  prdata_r <= {16'h0000, wdata_r};
          TSP_APB_STATUS: prdata_r <= {30'h0, nack_r, state_r != TSP_H_IDLE};
          TSP_APB_RDATA:  prdata_r <= {16'h0000, rdata_r};
          default:        prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Orders from software; CTRL is refused while busy
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ptr_r   <= 8'h00;
      op_r    <= TSP_OP_READ;
      two_r   <= 1'b0;
      strap_r <= 3'h0;
      wdata_r <= 16'h0000;
    end else begin
      if (go) begin
        ptr_r   <= pwdata[TSP_CTRL_PTR_LSB +: 8];
        op_r    <= tsp_op_t'(pwdata[TSP_CTRL_OP_LSB +: 2]);
        two_r   <= pwdata[TSP_CTRL_TWO_BIT];
        strap_r <= pwdata[TSP_CTRL_STRAP_LSB +: 3];
      end
      if (psel && penable && pready_r && pwrite && paddr == TSP_APB_WDATA) begin
        wdata_r <= pwdata[15:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Byte plan of the current transfer
  always_comb begin
    unique case (byte_r)
      2'h0:    tx_byte = {TSP_ADDR_FIXED, strap_r, op_r == TSP_OP_READ};
      // Selector resent in every write, upper three bits cleared except for the copy command
      2'h1:    tx_byte = (ptr_r == TSP_CMD_COPY) ? ptr_r :
                         {3'h0, ptr_r[4:0]};
      2'h2:    tx_byte = wdata_r[15:8];
      default: tx_byte = wdata_r[7:0];
    endcase
    unique case (op_r)
      TSP_OP_READ: nlast = two_r ? 2'h2 : 2'h1;
      TSP_OP_PTR:  nlast = 2'h1;
      TSP_OP_WR8:  nlast = 2'h2;
      default:     nlast = 2'h3;
    endcase
  end
  assign is_rx = (op_r == TSP_OP_READ) & (byte_r != 2'h0);
  assign last  = (byte_r == nlast);
  assign tick  = (qcnt_r == 7'h00);

  // Sensor data line synchroniser
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      sda_m <= link.sda;
      sda_s <= sda_m;
    end
  end

  // Quarter-bit timer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      qcnt_r <= QTR_LAST;
    end else if (state_r == TSP_H_IDLE || tick) begin
      qcnt_r <= QTR_LAST;
    end else begin
      qcnt_r <= qcnt_r - 7'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Line sequencer: four quarters per bit
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r  <= TSP_H_IDLE;
      ph_r     <= 2'h0;
      bit_r    <= 4'h0;
      byte_r   <= 2'h0;
      sh_r     <= 8'h00;
      nak_bit  <= 1'b0;
      nack_r   <= 1'b0;
      rdata_r  <= 16'h0000;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (state_r == TSP_H_IDLE) begin
      if (go) begin
        state_r <= TSP_H_START;
        ph_r    <= 2'h0;
        byte_r  <= 2'h0;
        nack_r  <= 1'b0;
      end
    end else if (tick) begin
      ph_r <= ph_r + 2'h1;
      unique case (state_r)
        TSP_H_START: begin
          if (ph_r == 2'h0) begin
            sda_oe_r <= 1'b1;
          end else begin
            scl_oe_r <= 1'b1;
            state_r  <= TSP_H_BITS;
            ph_r     <= 2'h0;
            bit_r    <= 4'h0;
            sh_r     <= tx_byte;
          end
        end
        TSP_H_BITS: begin
          unique case (ph_r)
            2'h0: begin
              if (bit_r != 4'h8) begin
                sda_oe_r <= ~is_rx & ~sh_r[7];
              end else begin
                sda_oe_r <= is_rx & ~last;
              end
            end
            2'h1: scl_oe_r <= 1'b0;
            2'h2: begin
              if (bit_r != 4'h8 && is_rx) begin
                sh_r <= {sh_r[6:0], sda_s};
              end
              nak_bit <= sda_s;
            end
            default: begin
              scl_oe_r <= 1'b1;
              if (bit_r != 4'h8) begin
                bit_r <= bit_r + 4'h1;
                if (!is_rx) begin
                  sh_r <= {sh_r[6:0], 1'b0};
                end
              end else begin
                bit_r <= 4'h0;
                if (is_rx && byte_r == 2'h1) begin
                  rdata_r[15:8] <= sh_r;
                end
                if (is_rx && byte_r == 2'h2) begin
                  rdata_r[7:0] <= sh_r;
                end
                if (!is_rx && nak_bit) begin
                  nack_r <= 1'b1;
                end
                if ((!is_rx && nak_bit) || last) begin
                  state_r <= TSP_H_STOP;
                end else begin
                  byte_r <= byte_r + 2'h1;
                end
              end
            end
          endcase
        end
        TSP_H_STOP: begin
          unique case (ph_r)
            2'h0:    sda_oe_r <= 1'b1;
            2'h1:    scl_oe_r <= 1'b0;
            2'h2:    sda_oe_r <= 1'b0;
            default: state_r  <= TSP_H_IDLE;
          endcase
        end
        default: state_r <= TSP_H_IDLE;
      endcase
    end else if (state_r == TSP_H_BITS && ph_r == 2'h0 && bit_r == 4'h0 &&
                 qcnt_r == QTR_LAST) begin
      sh_r <= (bit_r == 4'h0 && !is_rx) ? tx_byte : sh_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pins and bus outputs
  assign link.scl_h_o  = 1'b0;
  assign link.scl_h_oe = scl_oe_r;
  assign link.sda_h_o  = 1'b0;
  assign link.sda_h_oe = sda_oe_r;
  assign prdata        = prdata_r;
  assign pready        = pready_r;
  assign pslverr       = pslverr_r;
endmodule : tsp_bus_master

// ===== dv/tsp_link_props.sv
// Link checker: open-drain values and bit timing on the two-wire link.
// Assumes the bench ties it to the interface that joins both ends.
`timescale 1ns/1ps
module tsp_link_props (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic scl_h_o,
  input wire logic scl_h_oe,
  input wire logic sda_h_o,
  input wire logic sda_h_oe,
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////
  // Drivers only pull low; host data is checked only while the host holds scl low
  property p_dev_od; sda_d_oe |-> !sda_d_o && !sda; endproperty
  property p_host_od; scl_h_oe |-> !scl_h_o && (!sda_h_oe || !sda_h_o); endproperty
  // Device moves its data only while the clock is low, after sync delay
  property p_dev_edge; $changed(sda_d_oe) |-> !scl && !$past(scl); endproperty
  property p_dev_lag; $fell(scl) |-> $stable(sda_d_oe); endproperty
  // Clock phases last at least eight clk_sys cycles
  property p_scl_hi; $rose(scl) |-> scl [*8]; endproperty
  property p_scl_lo; $fell(scl) |-> !scl [*8]; endproperty
  // No device answer right after a start
  property p_start_q; scl && $fell(sda) |-> !sda_d_oe [*8]; endproperty
  property p_bit_hold; scl && $past(scl) && sda_d_oe |-> $stable(sda); endproperty
  a_dev_od: assert property (p_dev_od) else $error("device drives high");
  a_host_od: assert property (p_host_od) else $error("host drives high");
  a_dev_edge: assert property (p_dev_edge) else $error("device data moved");
  a_dev_lag: assert property (p_dev_lag) else $error("device too early");
  a_scl_hi: assert property (p_scl_hi) else $error("clock high short");
  a_scl_lo: assert property (p_scl_lo) else $error("clock low short");
  a_start_q: assert property (p_start_q) else $error("device drove at start");
  a_bit_hold: assert property (p_bit_hold) else $error("device bit unstable");
  c_start: cover property (scl && $fell(sda));
  c_ack: cover property ($rose(sda_d_oe));
  c_clk: cover property ($rose(scl));
endmodule : tsp_link_props

// ===== dv/temp_sensor_pointer_register_map_tb.sv
// Bench: APB orders to the controller, sensor end checked at its ports.
// Assumes the package timing of 63 clocks a quarter bit.
`timescale 1ns/1ps
module temp_sensor_pointer_register_map_tb;
  import tsp_pkg::*;
  logic        clk_sys, rst_b, psel, penable, pwrite, locked, pready, pslverr, cs, er, tvld;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, st, q;
  logic [2:0]  strap;
  logic [15:0] tv, cv, nv, acfg, alo, ahi;
  int          seed, n_errors, num_checks;
  tsp_link_if lk();
  tsp_sensor_dev tsp_sensor_dev_inst (.clk_sys(clk_sys), .rst_b(rst_b), .link(lk.dev),
    .address_strap_pins(strap), .temp_sample(tv), .temp_sample_valid(tvld),
    .regs_locked(locked), .conv_start(cs), .active_configuration(acfg),
    .active_low_limit(alo), .active_high_limit(ahi));
  tsp_bus_master tsp_bus_master_inst (.clk_sys(clk_sys), .rst_b(rst_b), .link(lk.host),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  tsp_link_props tsp_link_props_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .scl_h_o(lk.scl_h_o), .scl_h_oe(lk.scl_h_oe), .sda_h_o(lk.sda_h_o),
    .sda_h_oe(lk.sda_h_oe), .sda_d_o(lk.sda_d_o), .sda_d_oe(lk.sda_d_oe),
    .scl(lk.scl), .sda(lk.sda));
  ////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  // Value compare
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    i = 0;
    do begin @(posedge clk_sys); i++; end while (pready !== 1'h1 && i < 50);
    q = prdata; er = pslverr;
    psel <= 1'h0; penable <= 1'h0;
    // One idle edge so the next call never re-raises psel in this step
    @(posedge clk_sys);
    if (i >= 50) begin n_errors++; close_out(); end
  endtask : apb
  // Start a link operation and wait for busy to clear
  task automatic op(input logic [7:0] p, input logic [1:0] o, input logic [2:0] s,
                    input logic [15:0] wd);
    int i;
    apb(1'h1, TSP_APB_WDATA, {16'h0, wd});
    apb(1'h1, TSP_APB_CTRL, {17'h0, s, 2'h1, o, p});
    i = 0;
    do begin apb(1'h0, TSP_APB_STATUS, 32'h0); i++; end
    while (q[TSP_STAT_BUSY_BIT] !== 1'h0 && i < 30000);
    st = q;
    if (i >= 30000) begin n_errors++; close_out(); end
  endtask : op
  // Read two bytes and compare
  task automatic rd(input logic [15:0] exp);
    op(8'h00, TSP_OP_READ, strap, 16'h0);
    apb(1'h0, TSP_APB_RDATA, 32'h0);
    chk(q[15:0], exp);
  endtask : rd
  // Clock
  initial begin clk_sys = 1'h0; forever #20 clk_sys = ~clk_sys; end
  // Main sequence
  initial begin
    seed = 32'hED06B71A; n_errors = 0; num_checks = 0;
    strap = 3'($random(seed));
    tv = 16'($random(seed));
    cv = 16'($random(seed));
    nv = 16'($random(seed));
    {psel, penable, pwrite, locked, rst_b} = 5'h0; paddr = 8'h0; pwdata = 32'h0;
    tvld = 1'h1;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'h1;
    @(posedge clk_sys); #1;
    chk({15'h0, cs}, 16'h1);
    chk(alo, TSP_NV_LOW_RST);
    chk(ahi, TSP_NV_HIGH_RST);
    @(posedge clk_sys);
    apb(1'h0, 8'h10, 32'h0);
    chk({15'h0, er}, 16'h1);
    chk({15'h0, cs}, 16'h0);
    // Samples ignored from here on: the register keeps the old value
    tvld <= 1'h0;
    tv <= cv;
    rd(tv);
    op(TSP_SEL_CFG, TSP_OP_WR16, strap, cv);
    chk(acfg, cv);
    op(8'h25, TSP_OP_PTR, strap, 16'h0);
    chk({15'h0, st[TSP_STAT_NACK_BIT]}, 16'h1);
    rd(cv);
    op(TSP_SEL_NV_CFG, TSP_OP_WR16, strap, nv);
    chk(acfg, cv);
    rd(nv);
    op(TSP_CMD_COPY, TSP_OP_PTR, strap, 16'h0);
    chk(acfg, nv);
    op(TSP_SEL_TEMP, TSP_OP_WR16, strap, cv);
    chk({15'h0, st[TSP_STAT_NACK_BIT]}, 16'h1);
    op(TSP_SEL_CFG, TSP_OP_WR8, strap ^ 3'h1, cv);
    chk({15'h0, st[TSP_STAT_NACK_BIT]}, 16'h1);
    locked <= 1'h1;
    op(TSP_SEL_LOW, TSP_OP_WR16, strap, cv);
    chk(alo, TSP_NV_LOW_RST);
    locked <= 1'h0;
    op(TSP_SEL_CFG, TSP_OP_WR8, strap, {cv[15:8], cv[15:8]});
    chk(acfg, {cv[15:8], nv[7:0]});
    op(TSP_SEL_HIGH, TSP_OP_WR16, strap, ~cv);
    chk(ahi, ~cv);
    close_out();
  end
endmodule : temp_sensor_pointer_register_map_tb
